// ---- verilog/nwd_pkg.sv ----
/*
 Constants for the network watchdog and logic output block: register
 offsets, field positions, reset values, codes and timing figures.
 Assumes a single 125 MHz clock and a synchronous active-low reset.
*/
package nwd_pkg;

   // Register word addresses on the plain register port.
   localparam logic [3:0] ADDR_ERR_RESP = 4'h0;
   localparam logic [3:0] ADDR_TIMEOUT = 4'h1;
   localparam logic [3:0] ADDR_LOGIC = 4'h2;
   localparam logic [3:0] ADDR_TERM = 4'h3;
   localparam logic [3:0] ADDR_CTRL = 4'h4;
   localparam logic [3:0] ADDR_STATE = 4'h5;
   localparam logic [3:0] ADDR_STATUS = 4'h6;
   localparam logic [3:0] ADDR_MASK = 4'h7;

   // Field positions.
   localparam int LOGIC_A_LSB = 0;
   localparam int LOGIC_B_LSB = 4;
   localparam int LOGIC_OP_LSB = 8;
   localparam int TERM_W = 4;
   localparam int NUM_TERMS = 3;
   localparam int CTRL_CLEAR_BIT = 0;
   localparam int STAT_TIMEOUT = 0;
   localparam int STAT_TRIP = 1;
   localparam int STAT_RESUME = 2;
   localparam int NUM_EVENTS = 3;

   // Values after reset.
   localparam logic [2:0] RST_ERR_RESP = 3'h2;
   localparam logic [15:0] RST_TIMEOUT = 16'h0000;
   localparam logic [3:0] RST_OPERAND = 4'h0;
   localparam logic [1:0] RST_OPERATOR = 2'h0;
   localparam logic [3:0] RST_TERM = 4'hF;
   localparam logic [2:0] RST_MASK = 3'h0;

   // Error response codes.
   localparam logic [2:0] RESP_TRIP = 3'h0;
   localparam logic [2:0] RESP_TRIP_STOP = 3'h1;
   localparam logic [2:0] RESP_DISABLE = 3'h2;
   localparam logic [2:0] RESP_COAST = 3'h3;
   localparam logic [2:0] RESP_STOP = 3'h4;

   // Alarm code reported on a communications trip.
   localparam logic [7:0] ALARM_COMM = 8'h3C;

   // Boolean operator codes.
   localparam logic [1:0] OP_AND = 2'h0;
   localparam logic [1:0] OP_OR = 2'h1;
   localparam logic [1:0] OP_XOR = 2'h2;

   // Output function assignment codes.
   localparam logic [3:0] FUNC_NDC = 4'h8;
   localparam logic [3:0] FUNC_LOG = 4'h9;
   localparam int NUM_OTHER = 8;

   // Timeout period is counted in units of 10 ms.
   localparam int CLK_PERIOD_NS = 8;
   localparam int TIMEOUT_UNIT_NS = 10000000;
   localparam int TICK_CYCLES = TIMEOUT_UNIT_NS / CLK_PERIOD_NS;
   localparam int TICK_W = 21;

   typedef enum logic [1:0] {
      NWD_OFF = 2'b00,
      NWD_WATCH = 2'b01,
      NWD_EXPIRED = 2'b11
   } nwd_state_e;

endpackage

// ---- verilog/nwd_logic_out.sv ----
/*
 Logic output combiner: picks two operands from the other output
 functions and combines them with AND, OR or XOR, registered.
 Assumes its inputs come from logic on the same clock.
*/
`timescale 1ns/100ps
module nwd_logic_out (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic [8:0] funcIn,
   input wire logic [3:0] operandASelect,
   input wire logic [3:0] operandBSelect,
   input wire logic [1:0] boolOperatorSelect,
   output logic logOut
);

   logic opA;
   logic opB;
   logic next_logOut;

   // Codes past the nine other functions select a constant low.
   always_comb begin
      opA = 1'b0;
      opB = 1'b0;
      if (operandASelect <= nwd_pkg::FUNC_NDC) begin
         opA = funcIn[operandASelect];
      end
      if (operandBSelect <= nwd_pkg::FUNC_NDC) begin
         opB = funcIn[operandBSelect];
      end
      case (boolOperatorSelect)
         nwd_pkg::OP_AND: next_logOut = opA & opB;
         nwd_pkg::OP_OR: next_logOut = opA | opB;
         nwd_pkg::OP_XOR: next_logOut = opA ^ opB;
         default: next_logOut = 1'b0;
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         logOut <= 1'b0;
      end else begin
         logOut <= next_logOut;
      end
   end

endmodule

// ---- verilog/nwd_top.sv ----
/*
 Network watchdog and logic output block with its register port,
 interrupt logic and output terminal routing.
 Assumes commActivity is an asynchronous pin that pulses or toggles
 level on each valid communications event; otherFunc comes from logic
 on ref_clk.
*/
`timescale 1ns/100ps
module nwd_top #(
   parameter int TICK_CYCLES = nwd_pkg::TICK_CYCLES
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic [3:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWrite,
   input wire logic regRead,
   output logic [31:0] regRdata,
   input wire logic commActivity,
   input wire logic [7:0] otherFunc,
   output logic [2:0] terminalOut,
   output logic ndcOut,
   output logic tripOut,
   output logic [7:0] alarmCode,
   output logic motorStop,
   output logic motorCoast,
   output logic irq
);

   // Configuration registers.
   logic [2:0] commErrorResponseSel;
   logic [15:0] commTimeoutPeriod;
   logic [3:0] operandASelect;
   logic [3:0] operandBSelect;
   logic [1:0] boolOperatorSelect;
   logic [11:0] termAssign;
   logic [2:0] intMask;
   logic [2:0] intStatus;
   logic [2:0] next_commErrorResponseSel;
   logic [15:0] next_commTimeoutPeriod;
   logic [3:0] next_operandASelect;
   logic [3:0] next_operandBSelect;
   logic [1:0] next_boolOperatorSelect;
   logic [11:0] next_termAssign;
   logic [2:0] next_intMask;
   logic [2:0] next_intStatus;
   logic [31:0] next_regRdata;
   logic next_irq;
   logic clearTrip;

   // Activity synchroniser and edge detection.
   logic actMeta;
   logic actSync;
   logic actLast;
   logic actEvent;

   // Watchdog state.
   nwd_pkg::nwd_state_e state;
   nwd_pkg::nwd_state_e next_state;
   logic [nwd_pkg::TICK_W-1:0] tickCnt;
   logic [nwd_pkg::TICK_W-1:0] next_tickCnt;
   logic [15:0] periodCnt;
   logic [15:0] next_periodCnt;
   logic next_ndcOut;
   logic next_tripOut;
   logic [7:0] next_alarmCode;
   logic next_motorStop;
   logic next_motorCoast;
   logic timeoutEvent;
   logic resumeEvent;
   logic tripEvent;
   logic tickDone;

   // Logic output and terminal routing.
   logic logOut;
   logic [8:0] funcAll;
   logic [2:0] next_terminalOut;
   logic [2:0] events;

   // Register writes and read data.
   always_comb begin
      next_commErrorResponseSel = commErrorResponseSel;
      next_commTimeoutPeriod = commTimeoutPeriod;
      next_operandASelect = operandASelect;
      next_operandBSelect = operandBSelect;
      next_boolOperatorSelect = boolOperatorSelect;
      next_termAssign = termAssign;
      next_intMask = intMask;
      clearTrip = 1'b0;
      next_regRdata = 32'h0000_0000;
      if (regWrite) begin
         case (regAddr)
            nwd_pkg::ADDR_ERR_RESP: next_commErrorResponseSel =
               regWdata[2:0];
            nwd_pkg::ADDR_TIMEOUT: next_commTimeoutPeriod = regWdata[15:0];
            nwd_pkg::ADDR_LOGIC: begin
               next_operandASelect = regWdata[nwd_pkg::LOGIC_A_LSB +: 4];
               next_operandBSelect = regWdata[nwd_pkg::LOGIC_B_LSB +: 4];
               next_boolOperatorSelect =
                  regWdata[nwd_pkg::LOGIC_OP_LSB +: 2];
            end
            nwd_pkg::ADDR_TERM: next_termAssign = regWdata[11:0];
            nwd_pkg::ADDR_CTRL: clearTrip =
               regWdata[nwd_pkg::CTRL_CLEAR_BIT];
            nwd_pkg::ADDR_MASK: next_intMask = regWdata[2:0];
            default: clearTrip = 1'b0;
         endcase
      end
      if (regRead) begin
         case (regAddr)
            nwd_pkg::ADDR_ERR_RESP: next_regRdata =
               {29'h0, commErrorResponseSel};
            nwd_pkg::ADDR_TIMEOUT: next_regRdata = {16'h0, commTimeoutPeriod};
            nwd_pkg::ADDR_LOGIC: next_regRdata = {22'h0, boolOperatorSelect,
               operandBSelect, operandASelect};
            nwd_pkg::ADDR_TERM: next_regRdata = {20'h0, termAssign};
            nwd_pkg::ADDR_STATE: next_regRdata = {24'h0, state, logOut,
               motorCoast, motorStop, tripOut, ndcOut, actSync};
            nwd_pkg::ADDR_STATUS: next_regRdata = {29'h0, intStatus};
            nwd_pkg::ADDR_MASK: next_regRdata = {29'h0, intMask};
            default: next_regRdata = 32'h0000_0000;
         endcase
      end
   end

   // Sticky status bits: an event in the clearing read cycle survives.
   assign events = {resumeEvent, tripEvent, timeoutEvent};

   always_comb begin
      next_intStatus = intStatus;
      if (regRead && regAddr == nwd_pkg::ADDR_STATUS) begin
         next_intStatus = 3'h0;
      end
      next_intStatus = next_intStatus | events;
      next_irq = |(next_intStatus & intMask);
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         commErrorResponseSel <= nwd_pkg::RST_ERR_RESP;
         commTimeoutPeriod <= nwd_pkg::RST_TIMEOUT;
         operandASelect <= nwd_pkg::RST_OPERAND;
         operandBSelect <= nwd_pkg::RST_OPERAND;
         boolOperatorSelect <= nwd_pkg::RST_OPERATOR;
         termAssign <= {nwd_pkg::NUM_TERMS{nwd_pkg::RST_TERM}};
         intMask <= nwd_pkg::RST_MASK;
         intStatus <= 3'h0;
         regRdata <= 32'h0000_0000;
         irq <= 1'b0;
      end else begin
         commErrorResponseSel <= next_commErrorResponseSel;
         commTimeoutPeriod <= next_commTimeoutPeriod;
         operandASelect <= next_operandASelect;
         operandBSelect <= next_operandBSelect;
         boolOperatorSelect <= next_boolOperatorSelect;
         termAssign <= next_termAssign;
         intMask <= next_intMask;
         intStatus <= next_intStatus;
         regRdata <= next_regRdata;
         irq <= next_irq;
      end
   end

   // Two-stage synchroniser; the edge detector reads only the second.
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         actMeta <= 1'b0;
         actSync <= 1'b0;
         actLast <= 1'b0;
      end else begin
         actMeta <= commActivity;
         actSync <= actMeta;
         actLast <= actSync;
      end
   end

   assign actEvent = actSync ^ actLast;
   assign tickDone = (tickCnt == TICK_CYCLES[nwd_pkg::TICK_W-1:0] - 1'b1);

   // Watchdog timer and timeout response.
   always_comb begin
      next_state = state;
      next_tickCnt = tickCnt;
      next_periodCnt = periodCnt;
      next_ndcOut = ndcOut;
      next_tripOut = tripOut;
      next_alarmCode = alarmCode;
      next_motorStop = motorStop;
      next_motorCoast = motorCoast;
      timeoutEvent = 1'b0;
      resumeEvent = 1'b0;
      tripEvent = 1'b0;
      if (clearTrip) begin
         next_tripOut = 1'b0;
         next_alarmCode = 8'h00;
         next_motorStop = 1'b0;
         next_motorCoast = 1'b0;
      end
      case (state)
         nwd_pkg::NWD_OFF: begin
            next_ndcOut = 1'b0;
            next_tickCnt = '0;
            next_periodCnt = 16'h0000;
            if (commTimeoutPeriod != 16'h0000) begin
               next_state = nwd_pkg::NWD_WATCH;
            end
         end
         nwd_pkg::NWD_WATCH: begin
            next_ndcOut = 1'b0;
            if (commTimeoutPeriod == 16'h0000) begin
               next_state = nwd_pkg::NWD_OFF;
            end else if (actEvent) begin
               next_tickCnt = '0;
               next_periodCnt = 16'h0000;
            end else if (tickDone) begin
               next_tickCnt = '0;
               next_periodCnt = periodCnt + 16'h0001;
               if (periodCnt + 16'h0001 >= commTimeoutPeriod) begin
                  next_state = nwd_pkg::NWD_EXPIRED;
                  next_ndcOut = 1'b1;
                  timeoutEvent = 1'b1;
                  case (commErrorResponseSel)
                     nwd_pkg::RESP_TRIP: begin
                        next_tripOut = 1'b1;
                        next_alarmCode = nwd_pkg::ALARM_COMM;
                        next_motorCoast = 1'b1;
                        tripEvent = 1'b1;
                     end
                     nwd_pkg::RESP_TRIP_STOP: begin
                        next_tripOut = 1'b1;
                        next_alarmCode = nwd_pkg::ALARM_COMM;
                        next_motorStop = 1'b1;
                        tripEvent = 1'b1;
                     end
                     nwd_pkg::RESP_COAST: next_motorCoast = 1'b1;
                     nwd_pkg::RESP_STOP: next_motorStop = 1'b1;
                     default: tripEvent = 1'b0;
                  endcase
               end
            end else begin
               next_tickCnt = tickCnt + 1'b1;
            end
         end
         nwd_pkg::NWD_EXPIRED: begin
            next_ndcOut = 1'b1;
            if (commTimeoutPeriod == 16'h0000) begin
               next_state = nwd_pkg::NWD_OFF;
               next_ndcOut = 1'b0;
            end else if (actEvent) begin
               next_state = nwd_pkg::NWD_WATCH;
               next_ndcOut = 1'b0;
               next_tickCnt = '0;
               next_periodCnt = 16'h0000;
               resumeEvent = 1'b1;
            end
         end
         default: begin
            next_state = nwd_pkg::NWD_OFF;
            next_ndcOut = 1'b0;
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         state <= nwd_pkg::NWD_OFF;
         tickCnt <= '0;
         periodCnt <= 16'h0000;
         ndcOut <= 1'b0;
         tripOut <= 1'b0;
         alarmCode <= 8'h00;
         motorStop <= 1'b0;
         motorCoast <= 1'b0;
      end else begin
         state <= next_state;
         tickCnt <= next_tickCnt;
         periodCnt <= next_periodCnt;
         ndcOut <= next_ndcOut;
         tripOut <= next_tripOut;
         alarmCode <= next_alarmCode;
         motorStop <= next_motorStop;
         motorCoast <= next_motorCoast;
      end
   end

   // The watchdog output is the ninth of the other functions.
   assign funcAll = {ndcOut, otherFunc};

   nwd_logic_out u_logic (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .funcIn(funcAll),
      .operandASelect(operandASelect),
      .operandBSelect(operandBSelect),
      .boolOperatorSelect(boolOperatorSelect),
      .logOut(logOut)
   );

   // Each terminal shows the function its assignment code names.
   genvar t;
   generate
      for (t = 0; t < nwd_pkg::NUM_TERMS; t++) begin : g_term
         logic [3:0] code;
         assign code = termAssign[t*nwd_pkg::TERM_W +: nwd_pkg::TERM_W];
         always_comb begin
            if (code == nwd_pkg::FUNC_NDC) begin
               next_terminalOut[t] = ndcOut;
            end else if (code == nwd_pkg::FUNC_LOG) begin
               next_terminalOut[t] = logOut;
            end else if (code < nwd_pkg::FUNC_NDC) begin
               next_terminalOut[t] = otherFunc[code[2:0]];
            end else begin
               next_terminalOut[t] = 1'b0;
            end
         end
      end
   endgenerate

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         terminalOut <= 3'h0;
      end else begin
         terminalOut <= next_terminalOut;
      end
   end

endmodule

// ---- tb/nwd_asserts.sv ----
/*
 Port checker for nwd_top, bound into every instance.
 Assumes it sees only the top ports and the same TICK_CYCLES.
*/
`timescale 1ns/100ps
module nwd_asserts #(
   parameter int TICK_CYCLES = 4
) (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic [3:0] regAddr,
   input wire logic [31:0] regWdata,
   input wire logic regWrite,
   input wire logic regRead,
   input wire logic [31:0] regRdata,
   input wire logic commActivity,
   input wire logic [2:0] terminalOut,
   input wire logic ndcOut,
   input wire logic tripOut,
   input wire logic [7:0] alarmCode,
   input wire logic motorStop,
   input wire logic motorCoast
);
   localparam int RISE = 2 * TICK_CYCLES + 8;
   logic [15:0] tmo, next_tmo;
   logic [2:0] resp, next_resp;
   logic [3:0] term1, next_term1;
   logic [7:0] quiet, next_quiet;
   logic lastAct, next_lastAct;
   // Shadows of the written settings and a count of quiet cycles.
   always_comb begin
      next_tmo = tmo;
      next_resp = resp;
      next_term1 = term1;
      next_lastAct = commActivity;
      next_quiet = (quiet == 8'hFF) ? quiet : quiet + 8'h01;
      if (commActivity != lastAct) begin
         next_quiet = 8'h00;
      end
      if (regWrite && regAddr == nwd_pkg::ADDR_TIMEOUT) begin
         next_tmo = regWdata[15:0];
      end
      if (regWrite && regAddr == nwd_pkg::ADDR_ERR_RESP) begin
         next_resp = regWdata[2:0];
      end
      if (regWrite && regAddr == nwd_pkg::ADDR_TERM) begin
         next_term1 = regWdata[7:4];
      end
   end
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         tmo <= nwd_pkg::RST_TIMEOUT;
         resp <= nwd_pkg::RST_ERR_RESP;
         term1 <= nwd_pkg::RST_TERM;
         quiet <= 8'h00;
         lastAct <= commActivity;
      end else begin
         tmo <= next_tmo;
         resp <= next_resp;
         term1 <= next_term1;
         quiet <= next_quiet;
         lastAct <= next_lastAct;
      end
   end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!resetn);
   rdata_idle_a:
      assert property (!$past(regRead) |-> regRdata == 32'h0)
         else $error("read data not zero outside answer cycle");
   alarm_trip_a:
      assert property (alarmCode == (tripOut ? nwd_pkg::ALARM_COMM : 8'h00))
         else $error("alarm code does not follow trip");
   trip_latch_a:
      assert property (tripOut && !(regWrite && regWdata[0]
         && regAddr == nwd_pkg::ADDR_CTRL) |=> tripOut)
         else $error("trip dropped without clear");
   trip_action_a:
      assert property (tripOut |-> motorStop || motorCoast)
         else $error("trip without stop or coast");
   resume_clear_a:
      assert property (ndcOut && $changed(commActivity) |-> ##[1:6] !ndcOut)
         else $error("network detect held after activity");
   quiet_rise_a:
      assert property ($rose(ndcOut) |-> int'(quiet) >= TICK_CYCLES)
         else $error("network detect rose during activity");
   timeout_rise_a:
      assert property (quiet == 8'(RISE) && tmo == 16'h0001 |-> ndcOut)
         else $error("network detect missing after timeout");
   zero_off_a:
      assert property ((tmo == 16'h0000)[*3] |-> !ndcOut)
         else $error("network detect with zero timeout");
   disable_none_a:
      assert property ((resp == nwd_pkg::RESP_DISABLE)[*2] ##0 !tripOut
         |=> !tripOut)
         else $error("trip while response disabled");
   term_ndc_a:
      assert property ((term1 == nwd_pkg::FUNC_NDC && $stable(ndcOut))[*2]
         |-> terminalOut[1] == ndcOut)
         else $error("terminal does not show network detect");
endmodule
bind nwd_top nwd_asserts #(.TICK_CYCLES(TICK_CYCLES)) nwd_asserts_i (
   .ref_clk(ref_clk), .resetn(resetn), .regAddr(regAddr),
   .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
   .regRdata(regRdata), .commActivity(commActivity),
   .terminalOut(terminalOut), .ndcOut(ndcOut), .tripOut(tripOut),
   .alarmCode(alarmCode), .motorStop(motorStop), .motorCoast(motorCoast)
);

// ---- tb/nwd_host_model.sv ----
/*
 Network host model: toggles the activity pin every gap+1 cycles.
 Assumes the bench sets sending and gap after clock edges.
*/
`timescale 1ns/100ps
module nwd_host_model (
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic sending,
   input wire logic [7:0] gap,
   output logic commActivity
);
   logic [7:0] cnt;
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         cnt <= 8'h00;
         commActivity <= 1'b0;
      end else if (sending && cnt >= gap) begin
         cnt <= 8'h00;
         commActivity <= !commActivity;
      end else begin
         cnt <= cnt + 8'h01;
      end
   end
endmodule

// ---- tb/nwd_top_test.sv ----
/*
 Self-checking bench for nwd_top: registers, watchdog responses,
 interrupt and logic output. Assumes a shortened TICK_CYCLES.
*/
`timescale 1ns/100ps
module nwd_top_test;
   localparam int TICK = 4;
   localparam logic [31:0] RESET_VAL[10] = '{32'h2, 32'h0, 32'h0,
      32'hFFF, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
   logic ref_clk = 1'b0;
   logic resetn = 1'b0;
   logic [3:0] regAddr = 4'h0;
   logic [31:0] regWdata = 32'h0;
   logic regWrite = 1'b0;
   logic regRead = 1'b0;
   logic [7:0] otherFunc = 8'h00;
   logic sending = 1'b0;
   logic [7:0] gap = 8'h02;
   logic [31:0] regRdata;
   logic [2:0] terminalOut;
   logic [7:0] alarmCode;
   logic commActivity, ndcOut, tripOut, motorStop, motorCoast, irq;
   logic rdPend = 1'b0;
   logic [31:0] expQ[$];
   logic [3:0] sa, sb, sc;
   logic [2:0] code;
   logic [1:0] op;
   logic [7:0] f;
   logic a, b, res;
   int n_mismatch = 0;
   int checked = 0;
   int cycles = 0;
   int seed = 4759;
   always #4 ref_clk = !ref_clk;
   nwd_top #(.TICK_CYCLES(TICK)) nwd_top_i (
      .ref_clk(ref_clk), .resetn(resetn), .regAddr(regAddr),
      .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
      .regRdata(regRdata), .commActivity(commActivity),
      .otherFunc(otherFunc), .terminalOut(terminalOut), .ndcOut(ndcOut),
      .tripOut(tripOut), .alarmCode(alarmCode), .motorStop(motorStop),
      .motorCoast(motorCoast), .irq(irq)
   );
   nwd_host_model nwd_host_model_i (
      .ref_clk(ref_clk), .resetn(resetn), .sending(sending), .gap(gap),
      .commActivity(commActivity)
   );
   task automatic check(input string what, input logic [31:0] seen,
         input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic final_report;
      if (n_mismatch == 0 && checked > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   task automatic bus(input logic w, input logic [3:0] ad,
         input logic [31:0] d);
      regAddr <= ad;
      regWdata <= d;
      regWrite <= w;
      regRead <= !w;
      @(posedge ref_clk);
      regWrite <= 1'b0;
      regRead <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic rd(input logic [3:0] ad, input logic [31:0] e);
      expQ.push_back(e);
      bus(1'b0, ad, 32'h0);
   endtask
   task automatic waitNdc(input logic v);
      int k;
      k = 0;
      while (ndcOut !== v && k < 60) begin
         @(posedge ref_clk);
         k++;
      end
      check("ndcOut", ndcOut, v);
   endtask
   // Read answers are taken off the queue in the cycle after the strobe.
   always @(posedge ref_clk) begin
      if (rdPend) begin
         check("regRdata", regRdata, expQ.pop_front());
      end
      rdPend <= regRead;
      cycles++;
      if (cycles > 5000) begin
         n_mismatch++;
         final_report();
      end
   end
   initial begin
      repeat (20) @(posedge ref_clk);
      resetn <= 1'b1;
      @(posedge ref_clk);
      for (int i = 0; i < 10; i++) begin
         rd(4'(i), RESET_VAL[i]);
      end
      bus(1'b1, 4'h9, 32'hFFFF_FFFF);
      rd(4'h9, 32'h0);
      sending <= 1'b1;
      bus(1'b1, nwd_pkg::ADDR_TERM, 32'h089);
      bus(1'b1, nwd_pkg::ADDR_TIMEOUT, 32'h1);
      bus(1'b1, nwd_pkg::ADDR_MASK, 32'hFFFF_FFFF);
      rd(nwd_pkg::ADDR_MASK, 32'h7);
      for (int c = 0; c < 8; c++) begin
         code = 3'(c);
         gap <= 8'({$random(seed)} % 3);
         sending <= 1'b1;
         waitNdc(1'b0);
         bus(1'b1, nwd_pkg::ADDR_ERR_RESP, 32'(code));
         bus(1'b1, nwd_pkg::ADDR_MASK, 32'(code != 3'h2));
         repeat (30) begin
            @(posedge ref_clk);
            check("ndcOut", ndcOut, 1'b0);
         end
         sending <= 1'b0;
         waitNdc(1'b1);
         repeat (2) @(posedge ref_clk);
         check("tripOut", tripOut, code < 3'h2);
         check("motorStop", motorStop, code == 3'h1 || code == 3'h4);
         check("motorCoast", motorCoast, code == 3'h0 || code == 3'h3);
         check("alarmCode", alarmCode,
            code < 3'h2 ? nwd_pkg::ALARM_COMM : 8'h00);
         check("terminalOut1", terminalOut[1], 1'b1);
         check("irq", irq, code != 3'h2);
         rd(nwd_pkg::ADDR_STATUS, {29'h0, c > 0, code < 3'h2, 1'b1});
         repeat (2) @(posedge ref_clk);
         check("irq", irq, 1'b0);
         bus(1'b1, nwd_pkg::ADDR_CTRL, 32'h1);
         check("tripOut", tripOut, 1'b0);
      end
      bus(1'b1, nwd_pkg::ADDR_TIMEOUT, 32'h0);
      repeat (60) @(posedge ref_clk);
      check("ndcOut", ndcOut, 1'b0);
      for (int i = 0; i < 12; i++) begin
         sa = 4'({$random(seed)} % 16);
         sb = 4'({$random(seed)} % 16);
         sc = 4'({$random(seed)} % 16);
         op = 2'(i % 4);
         f = 8'($random(seed));
         otherFunc <= f;
         bus(1'b1, nwd_pkg::ADDR_LOGIC, {22'h0, op, sb, sa});
         bus(1'b1, nwd_pkg::ADDR_TERM, {20'h0, sc, 8'h89});
         rd(nwd_pkg::ADDR_LOGIC, {22'h0, op, sb, sa});
         // Code 8 picks network-detect, held low by the zero period.
         a = (sa >= nwd_pkg::FUNC_NDC) ? 1'b0 : f[sa[2:0]];
         b = (sb >= nwd_pkg::FUNC_NDC) ? 1'b0 : f[sb[2:0]];
         res = (op == nwd_pkg::OP_AND) ? a & b :
            (op == nwd_pkg::OP_OR) ? a | b :
            (op == nwd_pkg::OP_XOR) ? a ^ b : 1'b0;
         check("terminalOut0", terminalOut[0], res);
         check("terminalOut2", terminalOut[2], (sc < nwd_pkg::FUNC_NDC) ?
            f[sc[2:0]] : (sc == nwd_pkg::FUNC_LOG) ? res : 1'b0);
      end
      final_report();
   end
endmodule
